// [logic/fsb_top.sv]
// Notes on behaviour
// - Each program or erase runs with the pump on; pump goes off when it finishes.
// - Burst keeps the pump on only if the next burst was queued before completion.
// - Chained burst must hit the same 64-byte row; low six address bits zero start a row.
// - Security value high 1, low 0 is unsecured; any other value is secure.
// - Debug module enable is refused while secure; debug access to unsecured targets stays.
// - Backdoor enable bit 0 disables key unlocking entirely.
// - With key access mode set, writes to key locations are captured, not commanded.
// - Clearing key access mode with matching key makes the device unsecured until reset.
// - Key bytes are taken only from secure-memory code, never from debug.
// - Key lies in the vector block, so protecting that block protects the key.
// - Protection register accepts writes only from debug accesses.
// - Debug blank check finding flash erased unsecures until reset.
// - Option and protection bytes are copied into their register copies.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fsb_top
#(
  parameter int KEY_BYTES = 8
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Bus master origin, valid with the write address
  input wire logic bus_from_debug,
  input wire logic bus_code_secure,
  // Debug controller
  input wire logic dbg_enable_req,
  output logic dbg_enable,
  input wire logic bdm_mem_req,
  input wire logic bdm_target_secure,
  output logic bdm_mem_grant,
  // Nonvolatile locations
  input wire logic [7:0] nv_option_byte,
  input wire logic [7:0] nv_protect_byte,
  input wire logic [KEY_BYTES*8-1:0] nv_key,
  // Flash array
  output logic flash_start,
  output fsb_pkg::fsb_cmd_t flash_cmd,
  output logic pump_en,
  input wire logic flash_done,
  input wire logic flash_blank
);
  import fsb_pkg::*;

  localparam int KW = $clog2(KEY_BYTES);

  // Registers
  logic loaded_ff;
  logic [7:0] cfg_ff, opt_ff, prot_ff, data_ff;
  logic [15:0] addr_ff;
  logic [1:0] sec_ff;
  logic err_ff;
  // AXI holding state
  logic aw_v_ff, w_v_ff, aw_dbg_ff, aw_sec_ff;
  logic [7:0] aw_a_ff;
  logic [31:0] w_d_ff;
  logic [3:0] w_s_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // Security decode
  wire secure = (sec_ff != FSB_SEC_OPEN);
  wire backdoor_enable_bit = opt_ff[FSB_OPT_BACKDOOR_ENABLE_BIT];
  wire key_access_mode = cfg_ff[FSB_CFG_KEY_ACCESS_MODE];

  // Debug gating while secure
  assign dbg_enable = dbg_enable_req & !secure;
  assign bdm_mem_grant = bdm_mem_req & (!secure | !bdm_target_secure);

  // Write decode; both halves must be held and no response pending
  wire wr_go = aw_v_ff & w_v_ff & !bvalid_ff;
  wire lane0 = w_s_ff[0];
  wire wr_cfg = wr_go & (aw_a_ff == FSB_OFF_CFG);
  wire wr_prot = wr_go & (aw_a_ff == FSB_OFF_PROT);
  wire wr_addr = wr_go & (aw_a_ff == FSB_OFF_ADDR);
  wire wr_data = wr_go & (aw_a_ff == FSB_OFF_DATA);
  wire wr_cmd = wr_go & (aw_a_ff == FSB_OFF_CMD);
  wire wr_ro = wr_go & ((aw_a_ff == FSB_OFF_OPT) | (aw_a_ff == FSB_OFF_STAT));
  wire wr_map = wr_cfg | wr_prot | wr_addr | wr_data | wr_cmd | wr_ro;

  // Key window and protected vector block
  wire [15:0] key_off = addr_ff - FSB_KEY_BASE;
  wire in_key = (addr_ff >= FSB_KEY_BASE) & (key_off < 16'(KEY_BYTES));
  wire in_vec = (addr_ff >= FSB_VEC_BLOCK_BASE);
  wire is_mass = (w_d_ff[7:0] == FSB_CMD_MASS) | (w_d_ff[7:0] == FSB_CMD_BLANK);
  // Key lives inside the vector block, so this guard covers it as well
  wire blocked = prot_ff[FSB_PROT_VEC] & (in_vec | is_mass);

  // Key capture path instead of a command
  wire key_path = wr_cmd & key_access_mode & in_key & lane0;
  wire key_ok_src = aw_sec_ff & !aw_dbg_ff & backdoor_enable_bit;
  wire key_wr = key_path & key_ok_src;

  // Command issue
  logic cmd_ready, pump_busy;
  fsb_cmd_t cur_cmd, new_cmd;
  wire cmd_try = wr_cmd & !key_path & lane0;
  wire cmd_go = cmd_try & !blocked & cmd_ready;
  assign new_cmd = '{code: w_d_ff[7:0], addr: addr_ff, data: data_ff, dbg: aw_dbg_ff};

  // Protection writes from application code are refused
  wire prot_ok = wr_prot & aw_dbg_ff;
  wire wr_err = (wr_prot & !aw_dbg_ff) | (cmd_try & !cmd_go) | (key_path & !key_ok_src);

  // Key access mode edges drive capture reset and compare
  wire key_access_set = wr_cfg & lane0 & w_d_ff[FSB_CFG_KEY_ACCESS_MODE] & !key_access_mode;
  wire key_access_clr = wr_cfg & lane0 & !w_d_ff[FSB_CFG_KEY_ACCESS_MODE] & key_access_mode;
  logic key_match;

  fsb_key_cmp #(.KEY_BYTES(KEY_BYTES)) u_key
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .key_clear(key_access_set),
    .key_wr(key_wr),
    .key_idx(key_off[KW-1:0]),
    .key_data(data_ff),
    .key_check(key_access_clr & backdoor_enable_bit),
    .stored_key(nv_key),
    .key_match(key_match)
  );

  fsb_burst_pump u_pump
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmd_valid(cmd_go),
    .cmd_in(new_cmd),
    .cmd_ready(cmd_ready),
    .flash_done(flash_done),
    .flash_start(flash_start),
    .cur_cmd(cur_cmd),
    .pump_en(pump_en),
    .busy(pump_busy)
  );
  assign flash_cmd = cur_cmd;

  // Debug-run blank check that passes opens the part
  wire blank_open = flash_done & pump_busy & (cur_cmd.code == FSB_CMD_BLANK) & cur_cmd.dbg & flash_blank;

  // Reload of option, protection and security from nonvolatile bytes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      loaded_ff <= 1'b0;
      opt_ff <= FSB_ZERO8;
      prot_ff <= FSB_ZERO8;
      sec_ff <= FSB_SEC_RESET;
    end
    else if (!loaded_ff)
    begin
      loaded_ff <= 1'b1;
      opt_ff <= nv_option_byte;
      prot_ff <= nv_protect_byte;
      sec_ff <= nv_option_byte[1:0];
    end
    else
    begin
      if (prot_ok & lane0) prot_ff <= w_d_ff[7:0];
      // A wrong key leaves the state alone
      if (key_match | blank_open) sec_ff <= FSB_SEC_OPEN;
    end
  end

  // Software registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_ff <= FSB_ZERO8;
      addr_ff <= '0;
      data_ff <= FSB_ZERO8;
      err_ff <= 1'b0;
    end
    else
    begin
      if (wr_cfg & lane0) cfg_ff <= {7'h00, w_d_ff[FSB_CFG_KEY_ACCESS_MODE]};
      if (wr_addr & w_s_ff[0]) addr_ff[7:0] <= w_d_ff[7:0];
      if (wr_addr & w_s_ff[1]) addr_ff[15:8] <= w_d_ff[15:8];
      if (wr_data & lane0) data_ff <= w_d_ff[7:0];
      // Error is sticky; a new refusal wins over the clearing launch
      if (wr_err) err_ff <= 1'b1;
      else if (cmd_go) err_ff <= 1'b0;
    end
  end

  // Status word
  wire [31:0] stat_w = {26'h0000000, loaded_ff, err_ff, !cmd_ready, pump_busy, pump_en, secure};

  // Read decode
  wire rd_go = arvalid & arready;
  wire rd_hit = (araddr == FSB_OFF_CFG) | (araddr == FSB_OFF_OPT) | (araddr == FSB_OFF_PROT) |
                (araddr == FSB_OFF_STAT) | (araddr == FSB_OFF_ADDR) | (araddr == FSB_OFF_DATA) |
                (araddr == FSB_OFF_CMD);
  wire [31:0] rd_mux = (araddr == FSB_OFF_CFG) ? {24'h000000, cfg_ff} :
                       (araddr == FSB_OFF_OPT) ? {24'h000000, opt_ff} :
                       (araddr == FSB_OFF_PROT) ? {24'h000000, prot_ff} :
                       (araddr == FSB_OFF_STAT) ? stat_w :
                       (araddr == FSB_OFF_ADDR) ? {16'h0000, addr_ff} :
                       (araddr == FSB_OFF_DATA) ? {24'h000000, data_ff} :
                       (araddr == FSB_OFF_CMD) ? {24'h000000, cur_cmd.code} : 32'h00000000;

  // Slave is held off until the reload is done
  assign awready = loaded_ff & !aw_v_ff;
  assign wready = loaded_ff & !w_v_ff;
  assign arready = loaded_ff & !rvalid_ff;

  // Write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_v_ff <= 1'b0;
      w_v_ff <= 1'b0;
      aw_a_ff <= FSB_ZERO8;
      aw_dbg_ff <= 1'b0;
      aw_sec_ff <= 1'b0;
      w_d_ff <= '0;
      w_s_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= FSB_RESP_OKAY;
    end
    else
    begin
      if (awvalid & awready)
      begin
        aw_v_ff <= 1'b1;
        aw_a_ff <= {awaddr[7:2], 2'h0};
        aw_dbg_ff <= bus_from_debug;
        aw_sec_ff <= bus_code_secure;
      end
      if (wvalid & wready)
      begin
        w_v_ff <= 1'b1;
        w_d_ff <= wdata;
        w_s_ff <= wstrb;
      end
      if (wr_go)
      begin
        aw_v_ff <= 1'b0;
        w_v_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_map & !wr_err & !wr_ro) ? FSB_RESP_OKAY : FSB_RESP_SLVERR;
      end
      else if (bvalid_ff & bready)
        bvalid_ff <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= FSB_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? FSB_RESP_OKAY : FSB_RESP_SLVERR;
    end
    else if (rvalid_ff & rready)
      rvalid_ff <= 1'b0;
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
endmodule // fsb_top

// [logic/fsb_pkg.sv]
package fsb_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] FSB_OFF_CFG = 8'h00;
  localparam logic [7:0] FSB_OFF_OPT = 8'h04;
  localparam logic [7:0] FSB_OFF_PROT = 8'h08;
  localparam logic [7:0] FSB_OFF_STAT = 8'h0c;
  localparam logic [7:0] FSB_OFF_ADDR = 8'h10;
  localparam logic [7:0] FSB_OFF_DATA = 8'h14;
  localparam logic [7:0] FSB_OFF_CMD = 8'h18;
  // Field positions
  localparam int FSB_CFG_KEY_ACCESS_MODE = 0;
  localparam int FSB_OPT_BACKDOOR_ENABLE_BIT = 7;
  localparam int FSB_PROT_VEC = 0;
  localparam int FSB_ST_SECURE = 0;
  localparam int FSB_ST_PUMP = 1;
  localparam int FSB_ST_BUSY = 2;
  localparam int FSB_ST_FULL = 3;
  localparam int FSB_ST_ERR = 4;
  localparam int FSB_ST_LOADED = 5;
  // Security encoding: high bit 1, low bit 0 means unsecured
  localparam logic [1:0] FSB_SEC_OPEN = 2'h2;
  localparam logic [1:0] FSB_SEC_RESET = 2'h3;
  // Address map of the array
  localparam logic [15:0] FSB_VEC_BLOCK_BASE = 16'hfe00;
  localparam logic [15:0] FSB_KEY_BASE = 16'hffb0;
  localparam logic [5:0] FSB_ROW_START = 6'h00;
  localparam logic [15:0] FSB_ADDR_STEP = 16'h0001;
  // Command codes
  localparam logic [7:0] FSB_CMD_BLANK = 8'h05;
  localparam logic [7:0] FSB_CMD_PROG = 8'h20;
  localparam logic [7:0] FSB_CMD_BURST = 8'h25;
  localparam logic [7:0] FSB_CMD_ERASE = 8'h40;
  localparam logic [7:0] FSB_CMD_MASS = 8'h41;
  // AXI responses
  localparam logic [1:0] FSB_RESP_OKAY = 2'h0;
  localparam logic [1:0] FSB_RESP_SLVERR = 2'h2;
  localparam logic [7:0] FSB_ZERO8 = 8'h00;

  // One flash command as handed to the array
  typedef struct packed {
    logic [7:0] code;
    logic [15:0] addr;
    logic [7:0] data;
    logic dbg;
  } fsb_cmd_t;
endpackage

// [logic/fsb_burst_pump.sv]
`timescale 1ns/1ps
module fsb_burst_pump
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command in
  input wire logic cmd_valid,
  input fsb_pkg::fsb_cmd_t cmd_in,
  output logic cmd_ready,
  // Array side
  input wire logic flash_done,
  output logic flash_start,
  output fsb_pkg::fsb_cmd_t cur_cmd,
  output logic pump_en,
  output logic busy
);
  import fsb_pkg::*;

  typedef enum logic [1:0] {PS_IDLE = 2'b01, PS_RUN = 2'b10} fsb_pstate_t;

  fsb_pstate_t state_ff, nxt_state;
  fsb_cmd_t cur_ff, pend_ff;
  logic pend_v_ff, nxt_pend_v;
  logic start_ff, pump_ff, nxt_pump;
  logic take, same_row, both_burst, keep, launch, run_done;

  // One queue slot; a command taken on the done edge counts as late
  assign cmd_ready = !pend_v_ff;
  assign take = cmd_valid & cmd_ready;
  assign run_done = (state_ff == PS_RUN) & flash_done;
  assign both_burst = (cur_ff.code == FSB_CMD_BURST) & (pend_ff.code == FSB_CMD_BURST);
  assign same_row = (pend_ff.addr == cur_ff.addr + FSB_ADDR_STEP) & (pend_ff.addr[5:0] != FSB_ROW_START);
  assign keep = run_done & pend_v_ff & both_burst & same_row;
  assign launch = ((state_ff == PS_IDLE) & pend_v_ff) | keep;

  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      PS_IDLE: if (pend_v_ff) nxt_state = PS_RUN;
      PS_RUN: if (run_done & !keep) nxt_state = PS_IDLE;
    endcase
    nxt_pend_v = take ? 1'b1 : (launch ? 1'b0 : pend_v_ff);
    // Pump on for each command, off at completion unless the burst chains
    nxt_pump = launch ? 1'b1 : (run_done ? 1'b0 : pump_ff);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= PS_IDLE;
      pend_v_ff <= 1'b0;
      start_ff <= 1'b0;
      pump_ff <= 1'b0;
      cur_ff <= '0;
      pend_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      pend_v_ff <= nxt_pend_v;
      start_ff <= launch;
      pump_ff <= nxt_pump;
      if (take) pend_ff <= cmd_in;
      if (launch) cur_ff <= pend_ff;
    end
  end

  assign flash_start = start_ff;
  assign cur_cmd = cur_ff;
  assign pump_en = pump_ff;
  assign busy = (state_ff == PS_RUN) | pend_v_ff;
endmodule // fsb_burst_pump

// [logic/fsb_key_cmp.sv]
`timescale 1ns/1ps
module fsb_key_cmp
#(
  parameter int KEY_BYTES = 8
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Capture and check
  input wire logic key_clear,
  input wire logic key_wr,
  input wire logic [$clog2(KEY_BYTES)-1:0] key_idx,
  input wire logic [7:0] key_data,
  input wire logic key_check,
  input wire logic [KEY_BYTES*8-1:0] stored_key,
  output logic key_match
);
  import fsb_pkg::*;

  localparam int CW = $clog2(KEY_BYTES) + 1;
  localparam logic [CW-1:0] FULL = CW'(KEY_BYTES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [KEY_BYTES*8-1:0] entered_ff;
  logic [CW-1:0] cnt_ff;
  logic bad_ff;
  logic in_order;

  // Bytes must arrive base first, one index after another
  assign in_order = ({1'b0, key_idx} == cnt_ff);

  // Capture; an out-of-order byte spoils the whole attempt
  always_ff @(posedge aclk)
  begin
    if (!aresetn | key_clear)
    begin
      cnt_ff <= '0;
      bad_ff <= 1'b0;
      entered_ff <= '0;
    end
    else if (key_wr)
    begin
      if (in_order)
      begin
        entered_ff[key_idx*8 +: 8] <= key_data;
        cnt_ff <= cnt_ff + ONE;
      end
      else
        bad_ff <= 1'b1;
    end
  end

  assign key_match = key_check & !bad_ff & (cnt_ff == FULL) & (entered_ff == stored_key);
endmodule // fsb_key_cmp

// [sim/fsb_flash_model.sv]
`timescale 1ns/1ps
module fsb_flash_model
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command side
  input wire logic flash_start,
  input wire logic [7:0] lat,
  input wire logic erased,
  output logic flash_done,
  output logic flash_blank
);
  logic [7:0] cnt_ff;
  // Busy time is reloaded at each start, so slow and prompt answers come from one counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_ff <= 8'h00;
    else if (flash_start)
      cnt_ff <= lat;
    else if (cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
  end
  // Blank flag shows the wrong level away from done, so a careless sampler is caught
  assign flash_done = (cnt_ff == 8'h01);
  assign flash_blank = flash_done ? erased : !erased;
endmodule // fsb_flash_model

// [sim/fsb_top_monitor.sv]
`timescale 1ns/1ps
module fsb_top_monitor
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Debug gating
  input wire logic dbg_enable_req,
  input wire logic dbg_enable,
  input wire logic bdm_mem_req,
  input wire logic bdm_target_secure,
  input wire logic bdm_mem_grant,
  // Array side
  input wire logic flash_start,
  input fsb_pkg::fsb_cmd_t flash_cmd,
  input wire logic pump_en,
  input wire logic flash_done
);
  import fsb_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A command ends with nothing chained, or with the pump kept for the next one
  sequence s_done_alone;
    flash_done ##1 !flash_start;
  endsequence
  sequence s_done_kept;
    flash_done ##1 pump_en;
  endsequence
  // Pump follows the command it serves
  a_pump_start: assert property (flash_start |-> pump_en)
    else $error("pump off at command start");
  a_pump_off: assert property (s_done_alone |-> !pump_en)
    else $error("pump left on after command");
  a_pump_cause: assert property ($rose(pump_en) |-> flash_start)
    else $error("pump on without a command");
  a_chain_row: assert property (s_done_kept |-> flash_start && flash_cmd.code == FSB_CMD_BURST &&
    $past(flash_cmd.code) == FSB_CMD_BURST && flash_cmd.addr[5:0] != FSB_ROW_START &&
    flash_cmd.addr == $past(flash_cmd.addr) + FSB_ADDR_STEP)
    else $error("pump kept across a bad chain");
  a_start_pulse: assert property (flash_start |=> !flash_start)
    else $error("start longer than one cycle");
  a_cmd_hold: assert property (!flash_start |-> $stable(flash_cmd))
    else $error("command changed without start");
  // Debug gating never grants more than asked, and unsecured targets stay reachable
  a_dbg_gate: assert property (dbg_enable |-> dbg_enable_req)
    else $error("debug enabled without request");
  a_grant_open: assert property (bdm_mem_req && !bdm_target_secure |-> bdm_mem_grant)
    else $error("unsecured target refused");
  a_grant_req: assert property (bdm_mem_grant |-> bdm_mem_req)
    else $error("grant without request");
  // Answers stand until taken
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
endmodule // fsb_top_monitor

bind fsb_top fsb_top_monitor mon_u (.aclk, .aresetn, .bvalid, .bready, .bresp, .rvalid, .rready, .rdata,
  .dbg_enable_req, .dbg_enable, .bdm_mem_req, .bdm_target_secure, .bdm_mem_grant, .flash_start,
  .flash_cmd, .pump_en, .flash_done);

// [sim/flash_security_burst_test.sv]
`timescale 1ns/1ps
module flash_security_burst_test;
  import fsb_pkg::*;
  // Stored key; a wrong attempt flips one bit of the first byte
  localparam logic [63:0] KEY = 64'h8877665544332211;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, bus_from_debug, bus_code_secure, dbg_enable_req, dbg_enable;
  logic bdm_mem_req, bdm_target_secure, bdm_mem_grant, flash_start, pump_en, flash_done, flash_blank, erased;
  logic [7:0] awaddr, araddr, nv_option_byte, nv_protect_byte, lat;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, krsp;
  logic [63:0] nv_key;
  fsb_cmd_t flash_cmd;
  logic pq;
  int miscompares, samples_checked, starts, falls;

  fsb_top #(.KEY_BYTES(8)) dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .bus_from_debug, .bus_code_secure, .dbg_enable_req, .dbg_enable, .bdm_mem_req,
    .bdm_target_secure, .bdm_mem_grant, .nv_option_byte, .nv_protect_byte, .nv_key, .flash_start,
    .flash_cmd, .pump_en, .flash_done, .flash_blank);
  fsb_flash_model array_u (.aclk, .aresetn, .flash_start, .lat, .erased, .flash_done,
    .flash_blank);

  // Bus clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Starts and pump drops counted on the falling edge, where outputs are settled
  always @(negedge aclk)
  begin
    if (flash_start)
      starts++;
    if (pq && !pump_en)
      falls++;
    pq = pump_en;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [1:0] e, input logic [1:0] g);
    chk(n, {30'h0, e}, {30'h0, g});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  // Write: ready sampled at the falling edge; the answer is accepted one cycle late so held answers get a stall
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic fd);
    logic ta, tw, tb, bw;
    int k;
    ta = 0;
    tw = 0;
    tb = 0;
    bw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    bus_from_debug <= fd;
    bus_code_secure <= !fd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 60 && !tb; k++)
    begin
      @(negedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      tb = bvalid & bready;
      bw = bvalid;
      rsp = bresp;
      @(posedge aclk);
      awvalid <= !ta;
      wvalid <= !tw;
      bready <= bw & !tb;
    end
    chk("write answer", 32'h1, {31'h0, tb});
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr, rw;
    int k;
    ta = 0;
    tr = 0;
    rw = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 60 && !tr; k++)
    begin
      @(negedge aclk);
      ta = ta | arready;
      tr = rvalid & rready;
      rw = rvalid;
      rd_v = rdata;
      rsp = rresp;
      @(posedge aclk);
      arvalid <= !ta;
      rready <= rw & !tr;
    end
    chk("read answer", 32'h1, {31'h0, tr});
  endtask
  task automatic cmd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c, input logic fd);
    wr(FSB_OFF_ADDR, {16'h0, a}, fd);
    wr(FSB_OFF_DATA, {24'h0, d}, fd);
    wr(FSB_OFF_CMD, {24'h0, c}, fd);
  endtask
  task automatic wdone;
    int k;
    k = 0;
    do
      @(negedge aclk);
    while (!flash_done && ++k < 200);
    chk("done seen", 32'h1, {31'h0, flash_done});
  endtask
  task automatic sec(input logic e);
    rd(FSB_OFF_STAT);
    chk("secure", {31'h0, e}, {31'h0, rd_v[FSB_ST_SECURE]});
  endtask
  // Key entry from application code, bytes in ascending order with idle gaps
  task automatic key(input logic [63:0] v);
    int i;
    wr(FSB_OFF_CFG, 32'h1, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      cmd(FSB_KEY_BASE + 16'(i), v[8*i +: 8], FSB_CMD_PROG, 1'b0);
      krsp = rsp;
      cyc(2);
    end
    wr(FSB_OFF_CFG, 32'h0, 1'b0);
    cyc(3);
  endtask
  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(3);
  endtask
  task automatic t_boot;
    sec(1'b1);
    chk("loaded", 32'h1, {31'h0, rd_v[FSB_ST_LOADED]});
    rd(FSB_OFF_OPT);
    chk("option copy", {24'h0, nv_option_byte}, rd_v);
    rd(FSB_OFF_PROT);
    chk("protect copy", {24'h0, nv_protect_byte}, rd_v);
    rd(8'h1c);
    rchk("unmapped", FSB_RESP_SLVERR, rsp);
  endtask
  // Locked part with backdoor off: only the debug path unlocks it
  task automatic t_lock;
    @(posedge aclk);
    dbg_enable_req <= 1'b1;
    bdm_mem_req <= 1'b1;
    bdm_target_secure <= 1'b1;
    cyc(2);
    chk("debug enable", 32'h0, {31'h0, dbg_enable});
    chk("grant secure", 32'h0, {31'h0, bdm_mem_grant});
    @(posedge aclk);
    bdm_target_secure <= 1'b0;
    cyc(2);
    chk("grant open", 32'h1, {31'h0, bdm_mem_grant});
    wr(FSB_OFF_PROT, 32'h0, 1'b0);
    rchk("prot by app", FSB_RESP_SLVERR, rsp);
    rd(FSB_OFF_STAT);
    chk("err flag", 32'h1, {31'h0, rd_v[FSB_ST_ERR]});
    cmd(FSB_KEY_BASE, 8'h00, FSB_CMD_PROG, 1'b1);
    rchk("key block prog", FSB_RESP_SLVERR, rsp);
    cmd(16'h0000, 8'h00, FSB_CMD_MASS, 1'b1);
    rchk("mass blocked", FSB_RESP_SLVERR, rsp);
    key(KEY);
    rchk("key refused", FSB_RESP_SLVERR, krsp);
    sec(1'b1);
    wr(FSB_OFF_PROT, 32'h0, 1'b1);
    rchk("prot by debug", FSB_RESP_OKAY, rsp);
    rd(FSB_OFF_PROT);
    chk("prot cleared", 32'h0, rd_v);
    cmd(16'h0000, 8'h00, FSB_CMD_BLANK, 1'b1);
    wdone;
    cyc(3);
    sec(1'b1);
    erased <= 1'b1;
    cmd(16'h0000, 8'h00, FSB_CMD_BLANK, 1'b1);
    wdone;
    cyc(3);
    sec(1'b0);
    chk("debug enable open", 32'h1, {31'h0, dbg_enable});
  endtask
  task automatic t_prog;
    int s0;
    s0 = starts;
    cmd(16'h0100, 8'h5a, FSB_CMD_PROG, 1'b0);
    @(negedge aclk);
    chk("prog starts", 32'h1, 32'(starts - s0));
    chk("cmd code", {24'h0, FSB_CMD_PROG}, {24'h0, flash_cmd.code});
    chk("cmd addr", 32'h100, {16'h0, flash_cmd.addr});
    chk("cmd data", 32'h5a, {24'h0, flash_cmd.data});
    chk("pump on", 32'h1, {31'h0, pump_en});
    wdone;
    cyc(2);
    chk("pump off", 32'h0, {31'h0, pump_en});
  endtask
  // Slow array: second byte queued early, third crosses into a new row
  task automatic t_burst;
    int s0, f0;
    @(posedge aclk);
    lat <= 8'h28;
    s0 = starts;
    f0 = falls;
    cmd(16'h003e, 8'ha1, FSB_CMD_BURST, 1'b0);
    cmd(16'h003f, 8'ha2, FSB_CMD_BURST, 1'b0);
    wdone;
    cmd(16'h0040, 8'ha3, FSB_CMD_BURST, 1'b0);
    wdone;
    wdone;
    cyc(3);
    chk("burst starts", 32'h3, 32'(starts - s0));
    chk("pump drops", 32'h2, 32'(falls - f0));
  endtask
  task automatic t_keys;
    int s0;
    s0 = starts;
    key(KEY ^ 64'h1);
    chk("key starts", 32'(s0), 32'(starts));
    sec(1'b1);
    wr(FSB_OFF_CFG, 32'h1, 1'b0);
    cmd(FSB_KEY_BASE, KEY[7:0], FSB_CMD_PROG, 1'b1);
    rchk("debug key", FSB_RESP_SLVERR, rsp);
    wr(FSB_OFF_CFG, 32'h0, 1'b0);
    sec(1'b1);
    key(KEY);
    rchk("key taken", FSB_RESP_OKAY, krsp);
    sec(1'b0);
    chk("debug enable key", 32'h1, {31'h0, dbg_enable});
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence: locked part without backdoor, then a fresh boot with it
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, bus_from_debug} = '0;
    {bus_code_secure, dbg_enable_req, bdm_mem_req, bdm_target_secure, pq, erased} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    lat = 8'h03;
    nv_key = KEY;
    nv_option_byte = 8'h03;
    nv_protect_byte = 8'h01;
    rst;
    t_boot;
    t_lock;
    @(posedge aclk);
    nv_option_byte <= 8'h83;
    rst;
    sec(1'b1);
    t_prog;
    t_burst;
    t_keys;
    @(posedge aclk);
    nv_option_byte <= 8'h02;
    rst;
    sec(1'b0);
    end_of_test;
  end
  // Hang guard, well past the thousand or so cycles the run needs
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_of_test;
  end
endmodule // flash_security_burst_test
